// ==== rtl/motor_aux_pkg.sv ====
// shared types and constants for the motor pwm auxiliary block
package motor_aux_pkg;
  localparam int num_channels = 5;
  localparam int num_cc_sources = 16;
  localparam int num_dtc_sources = 17;
  localparam int num_shutdown_inputs = 4;
  localparam int num_phases = 6;
  localparam int counter_width = 16;
  localparam int bus_ctrl_lock_bit = 13;
  localparam logic [15:0] trough_value = 16'h0000;
  localparam logic toggle_initial_level = 1'b1;
  localparam logic commutation_from_hall = 1'b0;
  localparam logic commutation_from_soft = 1'b1;

  // capture/compare flag index per channel/register
  localparam int cc_ch0_base = 0;
  localparam int cc_ch1_base = 4;
  localparam int cc_ch2_base = 6;
  localparam int cc_ch3_base = 8;
  localparam int cc_ch4_base = 12;

  typedef struct packed {
    logic [num_cc_sources-1:0] capture_compare_flag;
    logic [num_channels-1:0] overflow_flag;
    logic [1:0] underflow_flag;
  } timer_status_type;

  typedef struct packed {
    logic [num_cc_sources-1:0] capture_compare_irq_enable;
    logic [num_channels-1:0] overflow_irq_enable;
    logic [1:0] underflow_irq_enable;
    logic adc_trigger_enable;
  } timer_irq_enable_type;

  typedef struct packed {
    logic carrier_toggle_enable;
    logic neg_phase_level_select;
    logic pos_phase_level_select;
  } output_control_type;

  typedef struct packed {
    logic commutation_source_select;
    logic neg_chop_enable;
    logic pos_chop_enable;
    logic phase_u_position;
    logic phase_v_position;
    logic phase_w_position;
  } gate_control_type;

  typedef struct packed {
    logic [num_cc_sources-1:0] irq_cc;
    logic [num_channels-1:0] irq_overflow;
    logic [1:0] irq_underflow;
    logic [num_dtc_sources-1:0] dtc_request;
    logic [num_channels-1:0] dma_request;
    logic adc_start_request;
  } request_out_type;
endpackage

// ==== rtl/timer_flag_bank.sv ====
// status flags with set-over-clear and level request outputs, except adc start, which follows the set events
`timescale 1ns/10ps
`default_nettype none
module timer_flag_bank
  import motor_aux_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire timer_status_type set_event,
  input wire timer_status_type clear_request,
  input wire timer_irq_enable_type enable,
  output timer_status_type status,
  output request_out_type requests
);
  typedef struct packed {
    timer_status_type flags;
    request_out_type req;
  } bank_state_type;

  bank_state_type state_q;
  bank_state_type state_d;
  logic [num_channels-1:0] reg_a_match_flag;

  always_comb
  begin
    state_d = state_q;
    // set wins over a clear in the same cycle
    state_d.flags = (state_q.flags & ~clear_request) | set_event;
    reg_a_match_flag = {state_d.flags.capture_compare_flag[cc_ch4_base],
      state_d.flags.capture_compare_flag[cc_ch3_base],
      state_d.flags.capture_compare_flag[cc_ch2_base],
      state_d.flags.capture_compare_flag[cc_ch1_base],
      state_d.flags.capture_compare_flag[cc_ch0_base]};
    state_d.req.irq_cc = state_d.flags.capture_compare_flag &
      enable.capture_compare_irq_enable;
    state_d.req.irq_overflow = state_d.flags.overflow_flag &
      enable.overflow_irq_enable;
    state_d.req.irq_underflow = state_d.flags.underflow_flag &
      enable.underflow_irq_enable;
    // only ch4 wrap event joins the cc events as transfer trigger
    state_d.req.dtc_request = {state_d.flags.overflow_flag[num_channels-1],
      state_d.flags.capture_compare_flag};
    state_d.req.dma_request = reg_a_match_flag;
    // ch4 register a left out: in complementary mode only ch0 to ch3 start the converter
    state_d.req.adc_start_request = enable.adc_trigger_enable &
      (set_event.capture_compare_flag[cc_ch0_base] |
      set_event.capture_compare_flag[cc_ch1_base] |
      set_event.capture_compare_flag[cc_ch2_base] |
      set_event.capture_compare_flag[cc_ch3_base]);
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign status = state_q.flags;
  assign requests = state_q.req;
endmodule // timer_flag_bank
`default_nettype wire

// ==== rtl/commutation_unit.sv ====
// six-phase commutation pattern for brushless motor drive
`timescale 1ns/10ps
`default_nettype none
module commutation_unit
  import motor_aux_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire gate_control_type gate_control_reg,
  input wire logic [2:0] position_inputs,
  input wire logic neg_phase_level_select,
  input wire logic pos_phase_level_select,
  input wire logic [2:0] pwm_chop,
  output logic [num_phases-1:0] phase_out
);
  typedef struct packed {
    logic [2:0] position_prev;
    logic [2:0] position_latched;
    logic [num_phases-1:0] out;
  } comm_state_type;

  comm_state_type state_q;
  comm_state_type state_d;
  logic [2:0] position_now;
  logic [2:0] pos_on;
  logic [2:0] neg_on;

  always_comb
  begin
    state_d = state_q;
    position_now = (gate_control_reg.commutation_source_select == commutation_from_hall) ?
      position_inputs :
      {gate_control_reg.phase_u_position, gate_control_reg.phase_v_position,
      gate_control_reg.phase_w_position};
    state_d.position_prev = position_now;
    // any edge on the selected source switches the pattern
    if (position_now != state_q.position_prev)
      state_d.position_latched = position_now;
    // phase k on-positive when its own bit set and next clear, negative vice versa
    pos_on = state_q.position_latched & ~{state_q.position_latched[1:0],
      state_q.position_latched[2]};
    neg_on = ~state_q.position_latched & {state_q.position_latched[1:0],
      state_q.position_latched[2]};
    for (int i = 0; i < 3; i++)
    begin
      state_d.out[2*i] = pos_on[i] ?
        ((gate_control_reg.pos_chop_enable ? pwm_chop[i] : 1'b1) ~^
        pos_phase_level_select) : ~pos_phase_level_select;
      state_d.out[2*i+1] = neg_on[i] ?
        ((gate_control_reg.neg_chop_enable ? ~pwm_chop[i] : 1'b1) ~^
        neg_phase_level_select) : ~neg_phase_level_select;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign phase_out = state_q.out;
endmodule // commutation_unit
`default_nettype wire

// ==== rtl/motor_pwm_aux.sv ====
// auxiliary functions of the complementary pwm timer
// Contract
// - carrier toggle output only when carrier_toggle_enable is 1
// - toggle inverts on upper counter cycle match and lower counter zero
// - toggle drives ch3 compare pin a, starting at 1
// - synchro plus sync clear: another channel clears both counters and subcounter
// - source bit 0: edges on three position inputs switch pattern
// - source bit 1: changes of u, v, w bits switch pattern
// - on phases chop when chop bit 1, steady level when 0
// - on level follows level select bits regardless of chop bits
// - adc start from register-a compare match of channels other than 4
// - bus control bit 13 locks writes; buffer registers always writable
// - any of four shutdown inputs forces six outputs to high impedance
// - clock stop detection forces six outputs to high impedance
// - events set sticky flags; request while flag and enable both 1
// - fixed priority within ch0, ch3 and ch4 (four sources each); between channels left to controller
// - sixteen capture/compare interrupt sources each with own enable
// - five overflow flags with overflow interrupt when enabled
// - underflow flags only on channels 1 and 2
// - seventeen transfer triggers: cc events plus ch4 wrap event
// - only register-a events trigger dma, five sources
// - adc request on ch0 to ch3 register-a flag set when trigger enabled
// - ch4 overflow flag set on underflow in complementary mode
// - software clears flag by reading 1 then writing 0
`timescale 1ns/10ps
`default_nettype none
module motor_pwm_aux
  import motor_aux_pkg::*;
#(
  parameter int width = counter_width
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic complementary_mode,
  input wire output_control_type output_control_reg,
  input wire gate_control_type gate_control_reg,
  input wire timer_irq_enable_type timer_irq_enable_reg,
  input wire logic [15:0] bus_control_reg_one,
  input wire logic channel_synchro_select,
  input wire logic sync_clear_selected,
  input wire logic other_channel_clear,
  input wire logic [width-1:0] upper_pwm_counter,
  input wire logic [width-1:0] lower_pwm_counter,
  input wire logic [width-1:0] cycle_compare_reg,
  input wire logic lower_counter_step,
  input wire logic [2:0] pwm_chop,
  input wire logic position_input_a,
  input wire logic position_input_b,
  input wire logic position_input_c,
  input wire logic [num_shutdown_inputs-1:0] shutdown_inputs,
  input wire logic clock_stop_detected,
  input wire timer_status_type hw_events,
  input wire logic [num_channels-1:0] underflow_events,
  input wire logic status_write,
  input wire timer_status_type status_write_data,
  input wire logic status_read,
  input wire timer_status_type transfer_clear,
  input wire logic protected_write_request,
  output logic protected_write_allow,
  output logic counter_clear,
  output logic ch3_compare_pin_a,
  output logic ch3_compare_pin_a_oe_n,
  output logic [num_phases-1:0] phase_pins,
  output logic [num_phases-1:0] phase_pins_oe_n,
  output timer_status_type timer_status_reg,
  output request_out_type requests,
  output logic [1:0] ch0_top_source,
  output logic [1:0] ch3_top_source,
  output logic [1:0] ch4_top_source
);
  typedef struct packed {
    logic toggle_active;
    logic toggle_level;
    timer_status_type read_seen;
    logic write_allow;
    logic clear_out;
    logic [num_phases-1:0] pins;
    logic [num_phases-1:0] pins_oe_n;
    logic [1:0] top0;
    logic [1:0] top3;
    logic [1:0] top4;
  } top_state_type;

  top_state_type state_q;
  top_state_type state_d;
  timer_status_type flags;
  timer_status_type set_event;
  timer_status_type clear_request;
  request_out_type flag_requests;
  logic [num_phases-1:0] comm_pins;
  logic halt;

  // highest-priority pending enabled source among four (index 0 first)
  function automatic logic [1:0] top_of_four(input logic [3:0] pending);
    logic [1:0] idx;
    idx = 2'h3;
    for (int i = 3; i >= 0; i--)
    begin
      if (pending[i])
        idx = 2'(i);
    end
    return idx;
  endfunction

  always_comb
  begin
    state_d = state_q;
    set_event = hw_events;
    // underflow flags only exist on channels 1 and 2
    set_event.underflow_flag = hw_events.underflow_flag | underflow_events[2:1];
    if (complementary_mode)
      set_event.overflow_flag[num_channels-1] = hw_events.overflow_flag[num_channels-1] |
        underflow_events[num_channels-1];
    // clear bits read as 1 beforehand and now written 0, and bits that transfer_clear names
    clear_request = (state_q.read_seen & ~status_write_data &
      {$bits(timer_status_type){status_write}}) | transfer_clear;
    if (status_read)
      state_d.read_seen = state_q.read_seen | flags;
    else if (status_write)
      state_d.read_seen = state_q.read_seen & status_write_data;

    state_d.write_allow = ~bus_control_reg_one[bus_ctrl_lock_bit] &
      protected_write_request;
    state_d.clear_out = complementary_mode & channel_synchro_select &
      sync_clear_selected & other_channel_clear;

    if (complementary_mode && output_control_reg.carrier_toggle_enable)
    begin
      if (!state_q.toggle_active)
      begin
        state_d.toggle_active = 1'b1;
        state_d.toggle_level = toggle_initial_level;
      end
      else if (upper_pwm_counter == cycle_compare_reg ||
        (lower_counter_step && lower_pwm_counter == width'(trough_value)))
        state_d.toggle_level = ~state_q.toggle_level;
    end
    else
    begin
      state_d.toggle_active = 1'b0;
      state_d.toggle_level = toggle_initial_level;
    end

    halt = |shutdown_inputs | clock_stop_detected;
    state_d.pins = comm_pins;
    state_d.pins_oe_n = {num_phases{halt}};

    state_d.top0 = top_of_four(flag_requests.irq_cc[cc_ch0_base +: 4]);
    state_d.top3 = top_of_four(flag_requests.irq_cc[cc_ch3_base +: 4]);
    state_d.top4 = top_of_four(flag_requests.irq_cc[cc_ch4_base +: 4]);
  end

  timer_flag_bank flag_bank
  (
    .clock(clock),
    .reset(reset),
    .set_event(set_event),
    .clear_request(clear_request),
    .enable(timer_irq_enable_reg),
    .status(flags),
    .requests(flag_requests)
  );

  commutation_unit commutation
  (
    .clock(clock),
    .reset(reset),
    .gate_control_reg(gate_control_reg),
    .position_inputs({position_input_a, position_input_b, position_input_c}),
    .neg_phase_level_select(output_control_reg.neg_phase_level_select),
    .pos_phase_level_select(output_control_reg.pos_phase_level_select),
    .pwm_chop(pwm_chop),
    .phase_out(comm_pins)
  );

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      state_q <= '0;
      state_q.toggle_level <= toggle_initial_level;
      state_q.pins_oe_n <= '1;
      state_q.top0 <= 2'h3;
      state_q.top3 <= 2'h3;
      state_q.top4 <= 2'h3;
    end
    else
      state_q <= state_d;
  end

  assign protected_write_allow = state_q.write_allow;
  assign counter_clear = state_q.clear_out;
  assign ch3_compare_pin_a = state_q.toggle_level;
  assign ch3_compare_pin_a_oe_n = ~state_q.toggle_active;
  assign phase_pins = state_q.pins;
  assign phase_pins_oe_n = state_q.pins_oe_n;
  assign timer_status_reg = flags;
  assign requests = flag_requests;
  assign ch0_top_source = state_q.top0;
  assign ch3_top_source = state_q.top3;
  assign ch4_top_source = state_q.top4;
endmodule // motor_pwm_aux
`default_nettype wire

// ==== test/motor_aux_checker.sv ====
// concurrent checks on the ports of the motor pwm auxiliary block
`timescale 1ns/10ps
`default_nettype none
module motor_aux_checker
  import motor_aux_pkg::*;
#(
  parameter int width = counter_width
)
(
  input wire logic clock,
  input wire logic reset,
  input wire logic complementary_mode,
  input wire output_control_type output_control_reg,
  input wire timer_irq_enable_type timer_irq_enable_reg,
  input wire logic [15:0] bus_control_reg_one,
  input wire logic channel_synchro_select,
  input wire logic sync_clear_selected,
  input wire logic other_channel_clear,
  input wire logic [width-1:0] upper_pwm_counter,
  input wire logic [width-1:0] lower_pwm_counter,
  input wire logic [width-1:0] cycle_compare_reg,
  input wire logic lower_counter_step,
  input wire logic [num_shutdown_inputs-1:0] shutdown_inputs,
  input wire logic clock_stop_detected,
  input wire timer_status_type hw_events,
  input wire logic [num_channels-1:0] underflow_events,
  input wire logic protected_write_request,
  input wire logic protected_write_allow,
  input wire logic counter_clear,
  input wire logic ch3_compare_pin_a,
  input wire logic [num_phases-1:0] phase_pins_oe_n,
  input wire timer_status_type timer_status_reg,
  input wire request_out_type requests
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_toggle_on;
    complementary_mode && output_control_reg.carrier_toggle_enable
      && $past(output_control_reg.carrier_toggle_enable) && $past(complementary_mode);
  endsequence
  // a trough match in the same cycle still gives only one inversion
  sequence s_upper_hit;
    upper_pwm_counter == cycle_compare_reg && !(lower_counter_step && lower_pwm_counter == '0);
  endsequence
  property p_toggle;
    s_toggle_on ##0 s_upper_hit |=> ch3_compare_pin_a == !$past(ch3_compare_pin_a);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle pin did not invert");
  property p_overflow;
    hw_events.overflow_flag != '0 |=> (timer_status_reg.overflow_flag
      & $past(hw_events.overflow_flag)) == $past(hw_events.overflow_flag);
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag not set");
  property p_underflow;
    underflow_events[2:1] != 2'h0 |=> (timer_status_reg.underflow_flag
      & $past(underflow_events[2:1])) == $past(underflow_events[2:1]);
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow flag not set");
  property p_ch4_wrap;
    complementary_mode && underflow_events[4] |=> timer_status_reg.overflow_flag[4];
  endproperty
  a_ch4_wrap: assert property (p_ch4_wrap) else $error("ch4 wrap flag not set");
  property p_dtc;
    hw_events.capture_compare_flag != '0 |=> (requests.dtc_request[15:0]
      & $past(hw_events.capture_compare_flag)) == $past(hw_events.capture_compare_flag);
  endproperty
  a_dtc: assert property (p_dtc) else $error("transfer request missing");
  property p_adc;
    hw_events.capture_compare_flag[0] && !timer_status_reg.capture_compare_flag[0]
      && timer_irq_enable_reg.adc_trigger_enable |=> requests.adc_start_request;
  endproperty
  a_adc: assert property (p_adc) else $error("conversion start missing");
  property p_halt;
    (shutdown_inputs != '0) || clock_stop_detected |=> phase_pins_oe_n == 6'h3f;
  endproperty
  a_halt: assert property (p_halt) else $error("phase pins still driven");
  property p_lock;
    protected_write_request && bus_control_reg_one[bus_ctrl_lock_bit] |=> !protected_write_allow;
  endproperty
  a_lock: assert property (p_lock) else $error("locked write allowed");
  property p_sync_clear;
    complementary_mode && channel_synchro_select && sync_clear_selected
      && other_channel_clear |=> counter_clear;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("sync clear missing");
endmodule // motor_aux_checker
`default_nettype wire

// ==== test/transfer_ctrl_model.sv ====
// far-side transfer controller that clears the flags which triggered it
`timescale 1ns/10ps
`default_nettype none
module transfer_ctrl_model
  import motor_aux_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic auto_clear_en,
  input wire request_out_type requests,
  output timer_status_type transfer_clear
);
  // a stalled controller leaves the flags to software
  always_ff @(posedge clock or posedge reset)
  begin
    transfer_clear <= '0;
    if (!reset && auto_clear_en)
    begin
      transfer_clear.capture_compare_flag <= requests.dtc_request[15:0];
      transfer_clear.overflow_flag[4] <= requests.dtc_request[16];
    end
  end
endmodule // transfer_ctrl_model
`default_nettype wire

// ==== test/tb.sv ====
// self-checking testbench for the motor pwm auxiliary block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import motor_aux_pkg::*;
  logic clock = 1'b0, reset = 1'b1, complementary_mode = 1'b1, auto_clear_en = 1'b0;
  output_control_type output_control_reg = '0;
  gate_control_type gate_control_reg = '0;
  timer_irq_enable_type timer_irq_enable_reg = '0;
  logic [15:0] bus_control_reg_one = 16'h0000, cycle_compare_reg = 16'h0100;
  logic [15:0] upper_pwm_counter = 16'h0001, lower_pwm_counter = 16'h0001;
  logic channel_synchro_select = 1'b0, sync_clear_selected = 1'b0, other_channel_clear = 1'b0;
  logic lower_counter_step = 1'b0, clock_stop_detected = 1'b0, protected_write_request = 1'b0;
  logic position_input_a = 1'b0, position_input_b = 1'b0, position_input_c = 1'b0;
  logic status_write = 1'b0, status_read = 1'b0;
  logic [2:0] pwm_chop = 3'h0;
  logic [3:0] shutdown_inputs = 4'h0;
  logic [4:0] underflow_events = 5'h00;
  timer_status_type hw_events = '0, status_write_data = '0, transfer_clear, timer_status_reg;
  logic protected_write_allow, counter_clear, ch3_compare_pin_a, ch3_compare_pin_a_oe_n;
  logic [5:0] phase_pins, phase_pins_oe_n;
  request_out_type requests;
  logic [1:0] ch0_top_source, ch3_top_source, ch4_top_source;
  int errors = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  motor_pwm_aux u_motor_pwm_aux (.*);
  transfer_ctrl_model u_transfer_ctrl_model (.*);
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic print_verdict;
    if (errors == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_toggle;
    chk(ch3_compare_pin_a_oe_n, 1'b1);
    @(posedge clock);
    output_control_reg.carrier_toggle_enable <= 1'b1;
    tick(2);
    chk({ch3_compare_pin_a, ch3_compare_pin_a_oe_n}, 2'h2);
    @(posedge clock);
    upper_pwm_counter <= 16'h0100;
    @(posedge clock);
    upper_pwm_counter <= 16'h0101;
    #1 chk(ch3_compare_pin_a, 1'b0);
    @(posedge clock);
    lower_pwm_counter <= 16'h0000;
    lower_counter_step <= 1'b1;
    @(posedge clock);
    lower_counter_step <= 1'b0;
    lower_pwm_counter <= 16'hffff;
    #1 chk(ch3_compare_pin_a, 1'b1);
  endtask
  task automatic t_flags;
    @(posedge clock);
    timer_irq_enable_reg <= '1;
    hw_events.capture_compare_flag <= 16'h0003;
    @(posedge clock);
    hw_events <= '0;
    #1 chk(timer_status_reg.capture_compare_flag, 16'h0003);
    chk(requests.irq_cc, 16'h0003);
    chk(requests.dtc_request[15:0], 16'h0003);
    chk(requests.dma_request, 5'h01);
    chk(requests.adc_start_request, 1'b1);
    @(posedge clock);
    timer_irq_enable_reg.capture_compare_irq_enable <= 16'h0002;
    status_write_data <= 23'h7f_ff7f;
    status_write <= 1'b1;
    @(posedge clock);
    status_write <= 1'b0;
    #1 chk(requests.adc_start_request, 1'b0);
    // ch0 sources 0 and 1 pending: register a wins
    chk(ch0_top_source, 2'h0);
    chk({ch3_top_source, ch4_top_source}, 4'hf);
    tick(1);
    chk(requests.irq_cc, 16'h0002);
    chk(timer_status_reg.capture_compare_flag, 16'h0003);
    chk(ch0_top_source, 2'h1);
    @(posedge clock);
    status_read <= 1'b1;
    @(posedge clock);
    status_read <= 1'b0;
    status_write <= 1'b1;
    @(posedge clock);
    status_write <= 1'b0;
    tick(1);
    chk(timer_status_reg.capture_compare_flag, 16'h0002);
  endtask
  task automatic t_under;
    @(posedge clock);
    underflow_events <= 5'h1f;
    hw_events.overflow_flag <= 5'h01;
    @(posedge clock);
    underflow_events <= 5'h00;
    hw_events <= '0;
    #1 chk(timer_status_reg.underflow_flag, 2'h3);
    chk(timer_status_reg.overflow_flag, 5'h11);
    chk(requests.irq_overflow, 5'h11);
    chk(requests.irq_underflow, 2'h3);
    // ch0 overflow must not reach the transfer triggers
    chk(requests.dtc_request, 17'h1_0002);
  endtask
  task automatic t_auto;
    @(posedge clock);
    auto_clear_en <= 1'b1;
    hw_events.capture_compare_flag <= 16'h0010;
    @(posedge clock);
    hw_events <= '0;
    #1 chk({requests.adc_start_request, requests.dma_request}, 6'h22);
    tick(3);
    chk(timer_status_reg.capture_compare_flag[4], 1'b0);
    @(posedge clock);
    hw_events.capture_compare_flag <= 16'h1000;
    @(posedge clock);
    hw_events <= '0;
    #1 chk({requests.adc_start_request, requests.dma_request}, 6'h10);
    @(posedge clock);
    auto_clear_en <= 1'b0;
  endtask
  task automatic t_halt;
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock);
      shutdown_inputs <= 4'(1 << i);
      clock_stop_detected <= (i == 4);
      tick(1);
      chk(phase_pins_oe_n, 6'h3f);
    end
    @(posedge clock);
    clock_stop_detected <= 1'b0;
  endtask
  task automatic t_comm;
    @(posedge clock);
    output_control_reg.neg_phase_level_select <= 1'b1;
    output_control_reg.pos_phase_level_select <= 1'b1;
    position_input_a <= 1'b1;
    tick(3);
    chk({phase_pins_oe_n, phase_pins}, 12'h012);
    @(posedge clock);
    gate_control_reg.pos_chop_enable <= 1'b1;
    gate_control_reg.neg_chop_enable <= 1'b1;
    pwm_chop <= 3'h5;
    tick(3);
    chk(phase_pins, 6'h10);
    @(posedge clock);
    gate_control_reg.pos_chop_enable <= 1'b0;
    gate_control_reg.neg_chop_enable <= 1'b0;
    gate_control_reg.commutation_source_select <= 1'b1;
    gate_control_reg.phase_v_position <= 1'b1;
    output_control_reg.neg_phase_level_select <= 1'b0;
    output_control_reg.pos_phase_level_select <= 1'b0;
    tick(3);
    chk(phase_pins, 6'h1b);
    @(posedge clock);
    gate_control_reg.phase_w_position <= 1'b1;
    tick(3);
    chk(phase_pins, 6'h1e);
  endtask
  task automatic t_lock_clear;
    @(posedge clock);
    protected_write_request <= 1'b1;
    bus_control_reg_one <= 16'h2000;
    channel_synchro_select <= 1'b1;
    sync_clear_selected <= 1'b1;
    other_channel_clear <= 1'b1;
    @(posedge clock);
    bus_control_reg_one <= 16'h0000;
    other_channel_clear <= 1'b0;
    #1 chk({protected_write_allow, counter_clear}, 2'h1);
    @(posedge clock);
    sync_clear_selected <= 1'b0;
    other_channel_clear <= 1'b1;
    @(posedge clock);
    other_channel_clear <= 1'b0;
    #1 chk({protected_write_allow, counter_clear}, 2'h2);
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    tick(1);
    t_toggle;
    t_flags;
    t_under;
    t_auto;
    t_halt;
    t_comm;
    t_lock_clear;
    print_verdict;
  end
  // the whole sequence needs a few hundred cycles at most
  initial
  begin
    #20000;
    errors++;
    print_verdict;
  end
endmodule // tb
bind motor_pwm_aux motor_aux_checker #(.width(width)) u_motor_aux_checker (.clock, .reset,
  .complementary_mode, .output_control_reg, .timer_irq_enable_reg, .bus_control_reg_one,
  .channel_synchro_select, .sync_clear_selected, .other_channel_clear, .upper_pwm_counter,
  .lower_pwm_counter, .cycle_compare_reg, .lower_counter_step, .shutdown_inputs,
  .clock_stop_detected, .hw_events, .underflow_events, .protected_write_request,
  .protected_write_allow, .counter_clear, .ch3_compare_pin_a, .phase_pins_oe_n,
  .timer_status_reg, .requests);
`default_nettype wire
